// [pkg/snc_pkg.sv]
package snc_pkg;
  localparam logic [7:0] OP_WR_UNLOCK   = 8'h06;
  localparam logic [7:0] OP_WR_LOCK     = 8'h04;
  localparam logic [7:0] OP_FEAT_RD     = 8'h0F;
  localparam logic [7:0] OP_FEAT_WR     = 8'h1F;
  localparam logic [7:0] OP_PAGE_RD     = 8'h13;
  localparam logic [7:0] OP_CACHE_RD    = 8'h03;
  localparam logic [7:0] OP_CACHE_RDF   = 8'h0B;
  localparam logic [7:0] OP_CACHE_RD2   = 8'h3B;
  localparam logic [7:0] OP_CACHE_RD4   = 8'h6B;
  localparam logic [7:0] OP_ID_RD       = 8'h9F;
  localparam logic [7:0] OP_LOAD        = 8'h02;
  localparam logic [7:0] OP_LOAD4       = 8'h32;
  localparam logic [7:0] OP_LOAD_RND    = 8'h84;
  localparam logic [7:0] OP_LOAD_RND4   = 8'h34;
  localparam logic [7:0] OP_PROG_EXEC   = 8'h10;
  localparam logic [7:0] OP_BLK_ERASE   = 8'hD8;
  localparam logic [7:0] OP_RESET       = 8'hFF;
  localparam logic [7:0] FA_PROTECT     = 8'hA0;
  localparam logic [7:0] FA_CONFIG      = 8'hB0;
  localparam logic [7:0] FA_STATUS      = 8'hC0;
  localparam logic [7:0] FA_DRIVE       = 8'hD0;
  localparam logic [7:0] PROTECT_RST    = 8'h38;
  localparam logic [7:0] CONFIG_RST     = 8'h90;
  localparam logic [7:0] DRIVE_RST      = 8'h40;
  localparam logic [7:0] PROTECT_WMASK  = 8'hBE;
  localparam logic [7:0] CONFIG_WMASK   = 8'hD1;
  localparam logic [7:0] DRIVE_WMASK    = 8'hE0;
  localparam int BIT_BUSY = 0;
  localparam int BIT_WLATCH = 1;
  localparam int BIT_EFAIL = 2;
  localparam int BIT_PFAIL = 3;
  localparam int BIT_QUAD = 0;
  localparam int BIT_OTP_EN = 6;
  localparam int BIT_OTP_LOCK = 7;
  localparam int BIT_CMP = 1;
  localparam int BIT_TB = 2;
  localparam int BIT_BP0 = 3;
  localparam int CACHE_BYTES = 2176;
  localparam int COL_W = 12;
  localparam int ROW_W = 16;
  localparam logic [5:0] PAGE_MASK = 6'h3F;
  localparam int CLK_MHZ = 10;
  localparam int READ_TIME_US = 135;
  localparam int PROG_TIME_US = 400;
  localparam int ERASE_TIME_US = 4000;
  localparam int RESET_TIME_US = 5;
  localparam int READ_CYC = READ_TIME_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int RESET_CYC = RESET_TIME_US * CLK_MHZ;
  localparam logic [7:0] MAKER_CODE = 8'h5A;
  localparam logic [7:0] PART_CODE = 8'h3C;
  localparam int FIFO_DEPTH = 16;
endpackage

// [hdl/snc_fifo.sv]
`timescale 1ns/1ps
module snc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         CLK,
  input  wire logic         rst_n,
  input  wire logic         clr,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic         push;
  logic         pop;

  assign in_ready  = (wp_r - rp_r) != (AW+1)'(D);
  assign out_valid = wp_r != rp_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (clr) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) mem_r[wp_r[AW-1:0]] <= in_data;
  end
endmodule

// [hdl/snc_array.sv]
`timescale 1ns/1ps
module snc_array (
  input  wire logic        CLK,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [1:0]  kind,
  input  wire logic        abort,
  output logic             busy,
  output logic             done
);
  logic [15:0] cnt_r;
  logic        busy_r;
  logic [15:0] load;

  // Kind 0 read, 1 program, 2 erase, 3 reset.
  always_comb begin
    case (kind)
      2'h0:    load = 16'(snc_pkg::READ_CYC);
      2'h1:    load = 16'(snc_pkg::PROG_CYC);
      2'h2:    load = 16'(snc_pkg::ERASE_CYC);
      default: load = 16'(snc_pkg::RESET_CYC);
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 16'h0000;
      busy_r <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r  <= load;
        busy_r <= 1'b1;
      end else if (abort) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        if (cnt_r <= 16'h0001) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end
  assign busy = busy_r;
endmodule

// [hdl/snc_sequencer.sv]
`timescale 1ns/1ps
module snc_sequencer (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic [3:0]  DQ_IN,
  output logic      [3:0]  DQ_OUT,
  output logic      [3:0]  DQ_OE,
  output logic [11:0]      CACHE_ADDR,
  output logic [7:0]       CACHE_WDATA,
  output logic             CACHE_WE,
  input  wire logic [7:0]  CACHE_RDATA,
  output logic [1:0]       ARRAY_OP,
  output logic [15:0]      ARRAY_ROW,
  output logic             ARRAY_START,
  output logic [7:0]       STATUS_VIEW
);
  typedef enum {S_OP, S_ADDR, S_DATA, S_IGNORE} snc_state_t;

  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic [1:0] sck_s_r, cs_s_r;
  logic [3:0] dq_s1_r, dq_s2_r;
  logic       sck_d_r, cs_d_r;
  logic       rise, fall, cs_rise;
  snc_state_t st_r;
  logic [7:0]  op_r;
  logic [7:0]  shin_r;
  logic [3:0]  bitc_r;
  logic [1:0]  bytc_r;
  logic [23:0] addr_r;
  logic [7:0]  shout_r;
  logic [1:0]  width_r;
  logic        out_on_r;
  logic [11:0] col_r;
  logic [7:0]  protect_r, config_r, drive_r, status_r;
  logic        byte_done;
  logic [7:0]  byte_in;
  logic        arr_busy, arr_done, arr_start, arr_abort;
  logic [1:0]  arr_kind;
  logic [7:0]  fifo_do;
  logic        fifo_dv, fifo_ir, fifo_push;
  logic        first_r;
  logic        skip_r;
  logic        reload_r;

  function automatic logic [3:0] step_for(input logic [1:0] w);
    step_for = (w == 2'd2) ? 4'd4 : (w == 2'd1) ? 4'd2 : 4'd1;
  endfunction

  // Rows protected for the current protection setting.
  function automatic logic row_protected(input logic [7:0] p, input logic [15:0] row);
    logic [2:0] lvl;
    lvl = p[snc_pkg::BIT_BP0 +: 3];
    row_protected = 1'b0;
    if (lvl == 3'h7) row_protected = 1'b1;
    else if (p[snc_pkg::BIT_CMP] && p[snc_pkg::BIT_TB] && lvl == 3'h6)
      row_protected = row[15:6] == 10'h000;
    else if (!p[snc_pkg::BIT_CMP] && p[snc_pkg::BIT_TB] && lvl != 3'h0 && lvl <= 3'h5)
      row_protected = (row >> (4'd10 + 4'(lvl - 3'h1))) == 16'h0000;
  endfunction

  function automatic logic is_busy_ok(input logic [7:0] op);
    is_busy_ok = op == snc_pkg::OP_FEAT_RD || op == snc_pkg::OP_RESET ||
                 op == snc_pkg::OP_ID_RD;
  endfunction

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) rst_sync_r <= 2'b00;
    else       rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // Pins are synchronised twice before any edge detection looks at them.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      sck_s_r <= 2'b00;
      cs_s_r  <= 2'b11;
      dq_s1_r <= 4'h0;
      dq_s2_r <= 4'h0;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      sck_s_r <= {sck_s_r[0], SCK};
      cs_s_r  <= {cs_s_r[0], CS_N};
      dq_s1_r <= DQ_IN;
      dq_s2_r <= dq_s1_r;
      sck_d_r <= sck_s_r[1];
      cs_d_r  <= cs_s_r[1];
    end
  end
  assign rise    = sck_s_r[1] && !sck_d_r && !cs_s_r[1];
  assign fall    = !sck_s_r[1] && sck_d_r && !cs_s_r[1];
  assign cs_rise = cs_s_r[1] && !cs_d_r;

  always_comb begin
    byte_in = shin_r;
    case (width_r)
      2'd2:    byte_in = {shin_r[3:0], dq_s2_r};
      2'd1:    byte_in = {shin_r[5:0], dq_s2_r[1:0]};
      default: byte_in = {shin_r[6:0], dq_s2_r[0]};
    endcase
  end
  assign byte_done = rise && (bitc_r + step_for(width_r)) >= 4'd8;

  snc_array u_array (
    .CLK   (CLK),
    .rst_n (rst_n),
    .start (arr_start),
    .kind  (arr_kind),
    .abort (arr_abort),
    .busy  (arr_busy),
    .done  (arr_done)
  );

  // Load data passes through a FIFO so cache writes never collide with reads.
  snc_fifo #(.W(8), .D(snc_pkg::FIFO_DEPTH)) u_fifo (
    .CLK       (CLK),
    .rst_n     (rst_n),
    .clr       (1'b0),
    .in_data   (byte_in),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ir),
    .out_data  (fifo_do),
    .out_valid (fifo_dv),
    .out_ready (!out_on_r)
  );

  assign fifo_push = byte_done && st_r == S_DATA && !out_on_r && fifo_ir &&
                     (op_r == snc_pkg::OP_LOAD || op_r == snc_pkg::OP_LOAD4 ||
                      op_r == snc_pkg::OP_LOAD_RND || op_r == snc_pkg::OP_LOAD_RND4);

  // Command decode and byte framing.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_OP;
      op_r <= 8'h00;
      shin_r <= 8'h00;
      bitc_r <= 4'h0;
      bytc_r <= 2'h0;
      addr_r <= 24'h000000;
      width_r <= 2'd0;
      first_r <= 1'b0;
    end else if (cs_s_r[1]) begin
      st_r <= S_OP;
      bitc_r <= 4'h0;
      bytc_r <= 2'h0;
      width_r <= 2'd0;
    end else if (rise) begin
      shin_r <= byte_in;
      bitc_r <= byte_done ? 4'h0 : bitc_r + step_for(width_r);
      if (byte_done) begin
        case (st_r)
          S_OP: begin
            op_r <= byte_in;
            bytc_r <= 2'h0;
            if (status_r[snc_pkg::BIT_BUSY] && !is_busy_ok(byte_in)) st_r <= S_IGNORE;
            else if (byte_in == snc_pkg::OP_CACHE_RD4 && !config_r[snc_pkg::BIT_QUAD])
              st_r <= S_IGNORE;
            else st_r <= S_ADDR;
          end
          S_ADDR: begin
            addr_r <= {addr_r[15:0], byte_in};
            bytc_r <= bytc_r + 2'h1;
            first_r <= 1'b1;
            if ((op_r == snc_pkg::OP_FEAT_RD || op_r == snc_pkg::OP_FEAT_WR ||
                 op_r == snc_pkg::OP_ID_RD) ||
                ((op_r == snc_pkg::OP_LOAD || op_r == snc_pkg::OP_LOAD4 ||
                  op_r == snc_pkg::OP_LOAD_RND || op_r == snc_pkg::OP_LOAD_RND4) &&
                 bytc_r == 2'h1) ||
                bytc_r == 2'h2) begin
              st_r <= S_DATA;
              if (op_r == snc_pkg::OP_LOAD4 || op_r == snc_pkg::OP_LOAD_RND4)
                width_r <= 2'd2;
            end
          end
          S_DATA: begin
            first_r <= 1'b0;
          end
          default: st_r <= S_IGNORE;
        endcase
      end
    end
  end

  // Cache column pointer; bytes past the cache end are dropped.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      col_r <= 12'h000;
      CACHE_WE <= 1'b0;
      CACHE_WDATA <= 8'h00;
    end else begin
      CACHE_WE <= 1'b0;
      if (st_r == S_ADDR && byte_done && bytc_r == 2'h1)
        col_r <= {addr_r[3:0], byte_in};
      else if (fifo_dv && !out_on_r) begin
        if (32'(col_r) < snc_pkg::CACHE_BYTES) begin
          CACHE_WE <= 1'b1;
          CACHE_WDATA <= fifo_do;
        end
      end
      if (CACHE_WE) col_r <= col_r + 12'h001;
      if (out_on_r && byte_done && st_r == S_DATA) col_r <= col_r + 12'h001;
    end
  end
  assign CACHE_ADDR = col_r;

  // Feature registers and command effects at chip-select rise.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      protect_r <= snc_pkg::PROTECT_RST;
      config_r  <= snc_pkg::CONFIG_RST;
      drive_r   <= snc_pkg::DRIVE_RST;
      status_r  <= 8'h00;
      arr_start <= 1'b0;
      arr_kind  <= 2'h0;
      arr_abort <= 1'b0;
      ARRAY_ROW <= 16'h0000;
    end else begin
      arr_start <= 1'b0;
      arr_abort <= 1'b0;
      status_r[snc_pkg::BIT_BUSY] <= arr_busy || arr_start;
      if (cs_rise && st_r != S_IGNORE) begin
        case (op_r)
          snc_pkg::OP_WR_UNLOCK: status_r[snc_pkg::BIT_WLATCH] <= 1'b1;
          snc_pkg::OP_WR_LOCK:   status_r[snc_pkg::BIT_WLATCH] <= 1'b0;
          snc_pkg::OP_FEAT_WR: if (st_r == S_DATA && !first_r) begin
            case (addr_r[7:0])
              snc_pkg::FA_PROTECT: protect_r <= shin_r & snc_pkg::PROTECT_WMASK;
              snc_pkg::FA_CONFIG:  config_r <= shin_r & snc_pkg::CONFIG_WMASK;
              snc_pkg::FA_DRIVE:   drive_r <= shin_r & snc_pkg::DRIVE_WMASK;
              default: ;
            endcase
          end
          snc_pkg::OP_PAGE_RD: if (st_r == S_DATA) begin
            ARRAY_ROW <= addr_r[15:0];
            arr_kind <= 2'h0;
            arr_start <= 1'b1;
          end
          snc_pkg::OP_PROG_EXEC, snc_pkg::OP_BLK_ERASE: if (st_r == S_DATA &&
              status_r[snc_pkg::BIT_WLATCH]) begin
            status_r[snc_pkg::BIT_WLATCH] <= 1'b0;
            status_r[snc_pkg::BIT_PFAIL] <= 1'b0;
            status_r[snc_pkg::BIT_EFAIL] <= 1'b0;
            ARRAY_ROW <= (op_r == snc_pkg::OP_BLK_ERASE) ?
                         (addr_r[15:0] & ~{10'h000, snc_pkg::PAGE_MASK}) : addr_r[15:0];
            if (row_protected(protect_r, addr_r[15:0])) begin
              if (op_r == snc_pkg::OP_PROG_EXEC) status_r[snc_pkg::BIT_PFAIL] <= 1'b1;
              else status_r[snc_pkg::BIT_EFAIL] <= 1'b1;
            end else begin
              arr_kind <= (op_r == snc_pkg::OP_PROG_EXEC) ? 2'h1 : 2'h2;
              arr_start <= 1'b1;
            end
          end
          snc_pkg::OP_RESET: begin
            // Feature registers stay; only the failure flags are cleared.
            status_r[snc_pkg::BIT_PFAIL] <= 1'b0;
            status_r[snc_pkg::BIT_EFAIL] <= 1'b0;
            arr_abort <= 1'b1;
            arr_kind <= 2'h3;
            arr_start <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
  assign ARRAY_OP = arr_kind;
  assign ARRAY_START = arr_start;
  assign STATUS_VIEW = status_r;

  // Output shifting for feature read, identification and cache read.
  // The host samples just before its rising edge, so a byte loaded on a rise must
  // survive the following fall unshifted; skip_r holds it for that one fall.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      shout_r <= 8'h00;
      out_on_r <= 1'b0;
      skip_r <= 1'b0;
      reload_r <= 1'b0;
    end else if (cs_s_r[1]) begin
      out_on_r <= 1'b0;
      skip_r <= 1'b0;
      reload_r <= 1'b0;
    end else if (rise && byte_done && st_r == S_ADDR &&
                 (op_r == snc_pkg::OP_FEAT_RD || op_r == snc_pkg::OP_ID_RD ||
                  bytc_r == 2'h2)) begin
      out_on_r <= 1'b1;
      skip_r <= 1'b1;
      case (op_r)
        snc_pkg::OP_FEAT_RD: case (byte_in)
          snc_pkg::FA_PROTECT: shout_r <= protect_r;
          snc_pkg::FA_CONFIG:  shout_r <= config_r;
          snc_pkg::FA_STATUS:  shout_r <= status_r;
          snc_pkg::FA_DRIVE:   shout_r <= drive_r;
          default:             shout_r <= 8'h00;
        endcase
        snc_pkg::OP_ID_RD: shout_r <= snc_pkg::MAKER_CODE;
        snc_pkg::OP_CACHE_RD, snc_pkg::OP_CACHE_RDF, snc_pkg::OP_CACHE_RD2,
        snc_pkg::OP_CACHE_RD4: shout_r <= CACHE_RDATA;
        default: out_on_r <= 1'b0;
      endcase
    end else if (rise && byte_done && st_r == S_DATA && out_on_r) begin
      skip_r <= 1'b1;
      if (op_r == snc_pkg::OP_ID_RD)
        shout_r <= first_r ? snc_pkg::PART_CODE : 8'h00;
      else
        reload_r <= 1'b1;
    end else if (fall && out_on_r) begin
      if (reload_r) begin
        // The column has advanced by now, so the next cache byte is on the bus.
        reload_r <= 1'b0;
        skip_r <= 1'b0;
        shout_r <= CACHE_RDATA;
      end else if (skip_r) begin
        skip_r <= 1'b0;
      end else begin
        shout_r <= shout_r << step_for(width_r);
      end
    end
  end

  // Wide reads switch the data lines after the address and dummy bytes.
  always_comb begin
    DQ_OUT = {3'b000, shout_r[7]};
    DQ_OE  = {3'b000, out_on_r};
    DQ_OE[0] = 1'b0;
    DQ_OE[1] = out_on_r;
    DQ_OUT[1] = shout_r[7];
    if (op_r == snc_pkg::OP_CACHE_RD2 && out_on_r) begin
      DQ_OUT = {2'b00, shout_r[7:6]};
      DQ_OE  = 4'h3;
    end else if (op_r == snc_pkg::OP_CACHE_RD4 && out_on_r) begin
      DQ_OUT = shout_r[7:4];
      DQ_OE  = 4'hF;
    end
  end

  busy_guard_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (st_r == S_OP && rise && byte_done && status_r[snc_pkg::BIT_BUSY] &&
     !is_busy_ok(byte_in)) |=> st_r == S_IGNORE)
    else $error("command accepted while busy");
  latch_clear_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (cs_rise && st_r != S_IGNORE && op_r == snc_pkg::OP_WR_LOCK)
    |=> !status_r[snc_pkg::BIT_WLATCH])
    else $error("write latch not cleared");
  no_latch_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (cs_rise && !status_r[snc_pkg::BIT_WLATCH] && op_r != snc_pkg::OP_PAGE_RD &&
     op_r != snc_pkg::OP_RESET) |=> !arr_start)
    else $error("program or erase without write latch");
  protect_all_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (arr_start && (arr_kind == 2'h1 || arr_kind == 2'h2))
    |-> !row_protected(protect_r, ARRAY_ROW))
    else $error("protected row altered");
  cache_bound_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CACHE_WE |-> 32'(col_r) < snc_pkg::CACHE_BYTES)
    else $error("cache write past end");
  quad_gate_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (DQ_OE == 4'hF) |-> config_r[snc_pkg::BIT_QUAD])
    else $error("quad output without quad bit");
  busy_start_a: assert property (@(posedge CLK) disable iff (!rst_n)
    arr_start |=> status_r[snc_pkg::BIT_BUSY])
    else $error("busy not reported");
  cs_end_a: assert property (@(posedge CLK) disable iff (!rst_n)
    cs_s_r[1] |=> (st_r == S_OP && !out_on_r))
    else $error("sequence not ended by chip select");
endmodule

// [tb/snc_host.sv]
`timescale 1ns/1ps
// Host model: clock idles low, MSB first, one line in each direction.
module snc_host (
  input  wire logic       CLK,
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      dq,
  input  wire logic [3:0] dq_out
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    dq = 4'h5;
  end
  task automatic half();
    repeat (4) @(posedge CLK);
    #1;
  endtask
  // Unused lines carry the inverse so a released line never looks held.
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    cs_n = 1'b0;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        dq = {{3{~tx[i][k]}}, tx[i][k]};
        half();
        sck = 1'b1;
        b[k] = dq_out[1];
        half();
        sck = 1'b0;
      end
      rx.push_back(b);
    end
    half();
    cs_n = 1'b1;
    dq = ~dq;
    half();
    half();
  endtask
endmodule

// [tb/spi_nand_command_sequencer_tb.sv]
`timescale 1ns/1ps
module spi_nand_command_sequencer_tb;
  logic        clk;
  logic        rstn;
  logic        sck;
  logic        cs_n;
  logic [3:0]  dq_in;
  logic [3:0]  dq_out;
  logic [3:0]  dq_oe;
  logic [11:0] c_addr;
  logic [7:0]  c_wdata;
  logic        c_we;
  logic [1:0]  a_op;
  logic [15:0] a_row;
  logic        a_start;
  logic [7:0]  stat;
  logic [7:0]  mem [0:2175];
  logic [7:0]  rx [$];
  int          n_errors;
  int          cmp_count;
  int          starts;
  int          writes;
  logic [1:0]  last_op;
  logic [15:0] last_row;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Registered outputs are looked at mid-cycle, away from the edge that launches them.
  always @(negedge clk) begin
    if (c_we === 1'b1) begin
      mem[c_addr] <= c_wdata;
      writes++;
    end
    if (a_start === 1'b1) begin
      starts++;
      last_op <= a_op;
      last_row <= a_row;
    end
  end

  snc_host snc_host_i (.CLK(clk), .sck(sck), .cs_n(cs_n), .dq(dq_in), .dq_out(dq_out));
  snc_sequencer snc_sequencer_i (
    .CLK(clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .CACHE_ADDR(c_addr), .CACHE_WDATA(c_wdata), .CACHE_WE(c_we),
    .CACHE_RDATA(mem[c_addr]), .ARRAY_OP(a_op), .ARRAY_ROW(a_row),
    .ARRAY_START(a_start), .STATUS_VIEW(stat));

  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s saw %h wanted %h", $time, m, s, e);
    end
  endtask
  task automatic xf(input logic [7:0] t[$]);
    snc_host_i.frame(t, rx);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // The longest operation the tests start is the program time, so the bound covers it.
  task automatic wait_idle();
    int i;
    for (i = 0; i < 6000 && stat[snc_pkg::BIT_BUSY] !== 1'b0; i++) @(posedge clk);
    if (i == 6000) begin
      n_errors++;
      $display("unexpected at %0t: busy never cleared", $time);
      tally_and_finish();
    end
  endtask
  task automatic rd_feat(input logic [7:0] a, input logic [7:0] e);
    xf('{snc_pkg::OP_FEAT_RD, a, 8'h00});
    chk(rx[2], e, "feature read");
  endtask

  task automatic t_defaults();
    rd_feat(snc_pkg::FA_PROTECT, snc_pkg::PROTECT_RST);
    rd_feat(snc_pkg::FA_CONFIG, snc_pkg::CONFIG_RST);
    rd_feat(snc_pkg::FA_DRIVE, snc_pkg::DRIVE_RST);
    rd_feat(8'h55, 8'h00);
    $display("defaults done");
  endtask
  task automatic t_latch();
    xf('{snc_pkg::OP_WR_UNLOCK});
    chk(stat[snc_pkg::BIT_WLATCH], 1'b1, "latch set");
    xf('{snc_pkg::OP_FEAT_WR, snc_pkg::FA_STATUS, 8'h00});
    chk(stat[snc_pkg::BIT_WLATCH], 1'b1, "status written");
    xf('{snc_pkg::OP_WR_LOCK});
    chk(stat[snc_pkg::BIT_WLATCH], 1'b0, "latch clear");
    xf('{snc_pkg::OP_FEAT_WR, snc_pkg::FA_PROTECT, 8'h00});
    rd_feat(snc_pkg::FA_PROTECT, 8'h00);
    $display("latch done");
  endtask
  task automatic t_id();
    xf('{snc_pkg::OP_ID_RD, 8'h00, 8'h00, 8'h00});
    chk({rx[2], rx[3]}, {snc_pkg::MAKER_CODE, snc_pkg::PART_CODE}, "id");
    $display("id done");
  endtask
  task automatic t_load();
    writes = 0;
    xf('{snc_pkg::OP_LOAD, 8'h08, 8'h7F, 8'hAA, 8'hBB});
    chk(writes, 1, "load count");
    chk(mem[2175], 8'hAA, "last column");
    xf('{snc_pkg::OP_LOAD_RND, 8'h00, 8'h10, 8'h5C});
    chk(mem[16], 8'h5C, "random byte");
    chk(mem[2175], 8'hAA, "kept byte");
    xf('{snc_pkg::OP_CACHE_RD, 8'h00, 8'h10, 8'h00, 8'h00});
    chk(rx[4], 8'h5C, "cache read");
    $display("load done");
  endtask
  task automatic t_page_read();
    starts = 0;
    xf('{snc_pkg::OP_PAGE_RD, 8'h00, 8'h12, 8'h34});
    chk({starts[1:0], last_op, last_row}, {2'h1, 2'h0, 16'h1234}, "page read");
    chk(stat[snc_pkg::BIT_BUSY], 1'b1, "read busy");
    xf('{snc_pkg::OP_WR_UNLOCK});
    chk(stat[snc_pkg::BIT_WLATCH], 1'b0, "unlock while busy");
    wait_idle();
    xf('{snc_pkg::OP_LOAD_RND, 8'h00, 8'h20, 8'h77});
    chk(mem[32], 8'h77, "move patch");
    xf('{snc_pkg::OP_WR_UNLOCK});
    starts = 0;
    xf('{snc_pkg::OP_PROG_EXEC, 8'h00, 8'h12, 8'h34});
    chk({starts[1:0], last_op, last_row}, {2'h1, 2'h1, 16'h1234}, "page move");
    wait_idle();
    $display("page read done");
  endtask
  task automatic t_program();
    starts = 0;
    xf('{snc_pkg::OP_PROG_EXEC, 8'h00, 8'h00, 8'h40});
    chk(starts, 0, "program unlatched");
    xf('{snc_pkg::OP_WR_UNLOCK});
    xf('{snc_pkg::OP_PROG_EXEC, 8'h00, 8'h00, 8'h40});
    chk({starts[1:0], last_op, last_row}, {2'h1, 2'h1, 16'h0040}, "program");
    chk(stat[snc_pkg::BIT_WLATCH], 1'b0, "latch after program");
    wait_idle();
    xf('{snc_pkg::OP_FEAT_WR, snc_pkg::FA_PROTECT, 8'h38});
    xf('{snc_pkg::OP_WR_UNLOCK});
    xf('{snc_pkg::OP_PROG_EXEC, 8'h00, 8'h00, 8'h80});
    chk(starts, 1, "protected program");
    chk(stat[snc_pkg::BIT_PFAIL], 1'b1, "program fail");
    $display("program done");
  endtask
  task automatic t_reset();
    xf('{snc_pkg::OP_FEAT_WR, snc_pkg::FA_PROTECT, 8'h08});
    xf('{snc_pkg::OP_RESET});
    wait_idle();
    chk(stat[snc_pkg::BIT_PFAIL], 1'b0, "fail after reset");
    rd_feat(snc_pkg::FA_PROTECT, 8'h08);
    $display("reset done");
  endtask

  initial begin
    rstn = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    starts = 0;
    writes = 0;
    for (int i = 0; i < 2176; i++) mem[i] = 8'h00;
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk);
    wait_idle();
    t_defaults();
    t_latch();
    t_id();
    t_load();
    t_page_read();
    t_program();
    t_reset();
    tally_and_finish();
  end
endmodule
